// *** hw/axis_homing_map.vh ***
`ifndef AXIS_HOMING_MAP_VH
`define AXIS_HOMING_MAP_VH

// homing method codes
`define HM_DATASET1 3'h0
`define HM_DATASET2 3'h1
`define HM_CRADLE 3'h2
`define HM_STOPPER1 3'h3
`define HM_STOPPER2 3'h4
`define HM_WIDTH 3

// minor error codes
`define ERR_NONE 8'h00
`define ERR_DONE_SET 8'h73
`define ERR_RETRY_BAD 8'h74
`define ERR_NO_ZERO 8'h78
`define ERR_WIDTH 8

// speed selections on the motion command
`define SPD_STOP 2'h0
`define SPD_HOME 2'h1
`define SPD_CREEP 2'h2

// position width
`define POS_WIDTH 32

// cycles spent in each deceleration phase
`define DECEL_TIME_NS 1000
`define CLK_PERIOD_NS 20
`define DECEL_CYCLES (`DECEL_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** hw/axis_homing_sequencer.v ***
`timescale 1ns/1ps
`include "axis_homing_map.vh"

module axis_homing_sequencer
(
  input wire clock_i,
  input wire resetn_i,
  input wire start_i,
  input wire [`HM_WIDTH-1:0] method_i,
  input wire home_dir_i,
  input wire [`POS_WIDTH-1:0] home_addr_i,
  input wire retry_en_i,
  input wire abs_support_i,
  input wire error_clear_i,
  input wire amp_power_up_i,
  input wire no_z_phase_opt_i,
  input wire zero_pulse_i,
  input wire dog_i,
  input wire torque_limiting_i,
  input wire in_position_flag_i,
  input wire motion_stopped_i,
  input wire [`POS_WIDTH-1:0] command_pos_i,
  input wire [`POS_WIDTH-1:0] real_pos_i,
  output reg [1:0] speed_sel_o,
  output reg move_dir_o,
  output reg torque_limit_en_o,
  output reg pos_load_o,
  output reg [`POS_WIDTH-1:0] pos_load_value_o,
  output reg [`POS_WIDTH-1:0] home_latch_o,
  output reg busy_o,
  output reg home_done_o,
  output reg [`ERR_WIDTH-1:0] minor_error_o,
  output reg zero_pass_flag_o
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_FWD = 4'h1;
  localparam [3:0] ST_DECEL1 = 4'h2;
  localparam [3:0] ST_REV = 4'h3;
  localparam [3:0] ST_DECEL2 = 4'h4;
  localparam [3:0] ST_CREEP = 4'h5;
  localparam [3:0] ST_PUSH = 4'h6;
  localparam [3:0] ST_SETTLE = 4'h7;
  localparam [3:0] ST_REV_OFF = 4'h8;
  // the count is reckoned as an integer and cut to the counter width on purpose
  localparam integer DECEL_LAST_INT = (`DECEL_CYCLES) - 1;
  localparam [7:0] DECEL_LAST = DECEL_LAST_INT[7:0];

  function is_stopper;
    input [`HM_WIDTH-1:0] m;
    begin
      is_stopper = (m == `HM_STOPPER1) || (m == `HM_STOPPER2);
    end
  endfunction

  function is_dataset;
    input [`HM_WIDTH-1:0] m;
    begin
      is_dataset = (m == `HM_DATASET1) || (m == `HM_DATASET2);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire zero_pass;
  wire dog_rise;
  wire tl_rise;

  zero_pass_tracker u_zero
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .amp_power_up_i(amp_power_up_i),
    .no_z_phase_opt_i(no_z_phase_opt_i),
    .zero_pulse_i(zero_pulse_i),
    .zero_pass_flag_o(zero_pass)
  );

  edge_rise u_dog
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .level_i(dog_i),
    .level_o(),
    .rise_o(dog_rise)
  );

  edge_rise u_tl
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .level_i(torque_limiting_i),
    .level_o(),
    .rise_o(tl_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [`HM_WIDTH-1:0] method_reg;
  reg dir_reg;
  reg [`POS_WIDTH-1:0] addr_reg;
  reg seen_zero_reg;
  reg seen_zero_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg [`POS_WIDTH-1:0] latch_next;
  reg latch_en;
  reg finish;
  reg [1:0] speed_next;
  reg dir_next;
  reg tl_next;
  reg [`ERR_WIDTH-1:0] err_start;

  // start screening, highest priority error first
  always @*
  begin
    err_start = `ERR_NONE;
    // done flag blocks cradle without retry
    if (method_i == `HM_CRADLE && home_done_o && !retry_en_i)
      err_start = `ERR_DONE_SET;
    else if (is_stopper(method_i) && home_done_o)
      err_start = `ERR_DONE_SET;
    else if (method_i == `HM_STOPPER1 && retry_en_i)
      err_start = `ERR_RETRY_BAD;
    // zero pass needed only by data set methods
    else if (is_dataset(method_i) && !zero_pass)
      err_start = `ERR_NO_ZERO;
  end

  always @*
  begin
    state_next = state_reg;
    seen_zero_next = seen_zero_reg | zero_pulse_i;
    cnt_next = cnt_reg;
    latch_next = home_latch_o;
    latch_en = 1'b0;
    finish = 1'b0;
    speed_next = speed_sel_o;
    dir_next = move_dir_o;
    tl_next = torque_limit_en_o;
    case (state_reg)
      ST_IDLE:
      begin
        seen_zero_next = 1'b0;
        if (start_i && !busy_o && err_start == `ERR_NONE)
        begin
          case (method_i)
            `HM_DATASET1:
            begin
              // command position taken, no motion, dog ignored
              latch_next = command_pos_i;
              latch_en = 1'b1;
              state_next = ST_SETTLE;
            end
            `HM_DATASET2:
            begin
              latch_next = real_pos_i;
              latch_en = 1'b1;
              state_next = ST_SETTLE;
            end
            `HM_CRADLE:
            begin
              if (dog_i)
              begin
                // start on dog: back off first
                speed_next = `SPD_HOME;
                dir_next = ~home_dir_i;
                state_next = ST_REV_OFF;
              end
              else
              begin
                speed_next = `SPD_HOME;
                dir_next = home_dir_i;
                state_next = ST_FWD;
              end
            end
            `HM_STOPPER1:
            begin
              dir_next = home_dir_i;
              if (dog_i)
              begin
                speed_next = `SPD_CREEP;
                tl_next = 1'b1;
                state_next = ST_PUSH;
              end
              else
              begin
                speed_next = `SPD_HOME;
                state_next = ST_FWD;
              end
            end
            default:
            begin
              // creep and torque limit from the start
              dir_next = home_dir_i;
              speed_next = `SPD_CREEP;
              tl_next = 1'b1;
              state_next = ST_PUSH;
            end
          endcase
        end
      end
      ST_FWD:
      begin
        if (dog_rise)
        begin
          cnt_next = 8'h00;
          if (method_reg == `HM_STOPPER1)
          begin
            // creep and torque limit after the dog edge
            speed_next = `SPD_CREEP;
            tl_next = 1'b1;
            state_next = ST_PUSH;
          end
          else
          begin
            speed_next = `SPD_STOP;
            state_next = ST_DECEL1;
          end
        end
      end
      ST_DECEL1:
      begin
        if (motion_stopped_i && cnt_reg >= DECEL_LAST)
        begin
          speed_next = `SPD_HOME;
          dir_next = ~dir_reg;
          seen_zero_next = 1'b0;
          state_next = ST_REV;
        end
        else if (cnt_reg < DECEL_LAST)
          cnt_next = cnt_reg + 8'h01;
      end
      ST_REV:
      begin
        // stop only once dog released and a zero pulse seen
        if (!dog_i && (seen_zero_reg || zero_pulse_i))
        begin
          speed_next = `SPD_STOP;
          cnt_next = 8'h00;
          state_next = ST_DECEL2;
        end
      end
      ST_REV_OFF:
      begin
        if (!dog_i)
        begin
          speed_next = `SPD_STOP;
          cnt_next = 8'h00;
          state_next = ST_DECEL2;
        end
      end
      ST_DECEL2:
      begin
        if (motion_stopped_i && cnt_reg >= DECEL_LAST)
        begin
          speed_next = `SPD_CREEP;
          dir_next = dir_reg;
          seen_zero_next = 1'b0;
          state_next = ST_CREEP;
        end
        else if (cnt_reg < DECEL_LAST)
          cnt_next = cnt_reg + 8'h01;
      end
      ST_CREEP:
      begin
        // first zero after dog comes on again
        if (zero_pulse_i && (dog_i || seen_zero_reg))
        begin
          latch_next = real_pos_i;
          latch_en = 1'b1;
          speed_next = `SPD_STOP;
          state_next = ST_SETTLE;
        end
        else
          seen_zero_next = seen_zero_reg | dog_i;
      end
      ST_PUSH:
      begin
        // torque-limit rising edge marks the stopper
        if (tl_rise)
        begin
          latch_next = real_pos_i;
          latch_en = 1'b1;
          speed_next = `SPD_STOP;
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        if (in_position_flag_i)
        begin
          finish = 1'b1;
          tl_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        speed_next = `SPD_STOP;
        state_next = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= ST_IDLE;
      method_reg <= `HM_DATASET1;
      dir_reg <= 1'b0;
      addr_reg <= {`POS_WIDTH{1'b0}};
      seen_zero_reg <= 1'b0;
      cnt_reg <= 8'h00;
      speed_sel_o <= `SPD_STOP;
      move_dir_o <= 1'b0;
      torque_limit_en_o <= 1'b0;
      pos_load_o <= 1'b0;
      pos_load_value_o <= {`POS_WIDTH{1'b0}};
      home_latch_o <= {`POS_WIDTH{1'b0}};
      busy_o <= 1'b0;
      home_done_o <= 1'b0;
      minor_error_o <= `ERR_NONE;
      zero_pass_flag_o <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      seen_zero_reg <= seen_zero_next;
      cnt_reg <= cnt_next;
      speed_sel_o <= speed_next;
      move_dir_o <= dir_next;
      torque_limit_en_o <= tl_next;
      zero_pass_flag_o <= zero_pass;
      busy_o <= (state_next != ST_IDLE);
      if (latch_en)
        home_latch_o <= latch_next;
      if (state_reg == ST_IDLE && start_i && !busy_o)
      begin
        method_reg <= method_i;
        dir_reg <= home_dir_i;
        addr_reg <= home_addr_i;
        // refused start leaves motion untouched and reports why
        if (err_start != `ERR_NONE)
          minor_error_o <= err_start;
        else
          home_done_o <= 1'b0;
      end
      else if (error_clear_i)
        minor_error_o <= `ERR_NONE;
      pos_load_o <= finish;
      if (finish)
      begin
        pos_load_value_o <= addr_reg;
        home_done_o <= 1'b1;
      end
    end
  end

endmodule // axis_homing_sequencer

// *** hw/edge_rise.v ***
`timescale 1ns/1ps
`include "axis_homing_map.vh"

module edge_rise
(
  input wire clock_i,
  input wire resetn_i,
  input wire level_i,
  output wire level_o,
  output wire rise_o
);

  reg level_reg;

  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      level_reg <= 1'b0;
    else
      level_reg <= level_i;
  end

  assign level_o = level_reg;
  assign rise_o = level_i & ~level_reg;

endmodule // edge_rise

// *** hw/zero_pass_tracker.v ***
`timescale 1ns/1ps
`include "axis_homing_map.vh"

module zero_pass_tracker
(
  input wire clock_i,
  input wire resetn_i,
  input wire amp_power_up_i,
  input wire no_z_phase_opt_i,
  input wire zero_pulse_i,
  output reg zero_pass_flag_o
);

  // sticky since amplifier power-up; power-up itself clears it unless the option waives it or a zero pulse comes in the same cycle
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      zero_pass_flag_o <= 1'b0;
    else if (zero_pulse_i)
      zero_pass_flag_o <= 1'b1;
    else if (amp_power_up_i)
      zero_pass_flag_o <= no_z_phase_opt_i;
  end

endmodule // zero_pass_tracker

// *** sim/axis_homing_sequencer_bench.sv ***
`timescale 1ns/1ps
`include "axis_homing_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module axis_homing_sequencer_bench;
  reg clock_i = 0, resetn_i = 0, start_i = 0, retry = 0, eclr = 0, pwr = 0, opt = 0, hold = 0;
  reg manual_jog_motion = 0;
  reg [2:0] method = 0;
  wire [1:0] spd;
  wire dir, tl_en, load, busy, done, zp, zpul, dog, tl, inpos, stopped;
  wire [31:0] lval, latch, cpos, rpos;
  wire [7:0] err;
  reg [45:0] rows [0:5];
  int miscompares = 0, cmp_count = 0, cyc = 0, i;
  always #10 clock_i = ~clock_i;
  axis_homing_sequencer u_axis_homing_sequencer (.clock_i(clock_i), .resetn_i(resetn_i),
    .start_i(start_i), .method_i(method), .home_dir_i(1'b1), .home_addr_i(32'h1234),
    .retry_en_i(retry), .abs_support_i(1'b0), .error_clear_i(eclr), .amp_power_up_i(pwr),
    .no_z_phase_opt_i(opt), .zero_pulse_i(zpul), .dog_i(dog), .torque_limiting_i(tl),
    .in_position_flag_i(inpos), .motion_stopped_i(stopped), .command_pos_i(cpos),
    .real_pos_i(rpos), .speed_sel_o(spd), .move_dir_o(dir), .torque_limit_en_o(tl_en),
    .pos_load_o(load), .pos_load_value_o(lval), .home_latch_o(latch), .busy_o(busy),
    .home_done_o(done), .minor_error_o(err), .zero_pass_flag_o(zp));
  servo_amp_model u_servo_amp_model (.clock_i(clock_i), .resetn_i(resetn_i),
    .speed_sel_i(spd), .move_dir_i(dir), .torque_limit_en_i(tl_en), .hold_i(hold), .jog_i(manual_jog_motion),
    .zero_pulse_o(zpul), .dog_o(dog), .torque_limiting_o(tl), .in_position_o(inpos),
    .motion_stopped_o(stopped), .real_pos_o(rpos), .command_pos_o(cpos));
  task tick;
    @(posedge clock_i);
    #1;
  endtask
  task go(input [2:0] m, input r);
    int k;
    method = m;
    retry = r;
    start_i = 1;
    tick;
    start_i = 0;
    repeat (2) tick;
    for (k = 0; k < 3000 && busy !== 1'b0; k++) tick;
  endtask
  // reset, amplifier power-up, then an optional forward jog of j cycles
  task prep(input o, input int j);
    resetn_i = 0;
    repeat (8) tick;
    resetn_i = 1;
    opt = o;
    pwr = 1;
    tick;
    pwr = 0;
    repeat (2) tick;
    if (j > 0)
    begin
      manual_jog_motion = 1;
      repeat (j) tick;
      manual_jog_motion = 0;
      tick;
    end
  endtask
  task run(input [2:0] m, input r, input o, input int j);
    prep(o, j);
    go(m, r);
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, runs are a few hundred cycles each except the held in-position run, about 3000
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      results;
    end
  end
  initial
  begin
    // method, retry, option, error, done, latched home
    rows[0] = {`HM_DATASET1, 1'b0, 1'b1, `ERR_NONE, 1'b1, 32'h15};
    rows[1] = {`HM_DATASET2, 1'b0, 1'b1, `ERR_NONE, 1'b1, 32'h10};
    rows[2] = {`HM_DATASET2, 1'b0, 1'b0, `ERR_NO_ZERO, 1'b0, 32'h0};
    rows[3] = {`HM_STOPPER1, 1'b1, 1'b0, `ERR_RETRY_BAD, 1'b0, 32'h0};
    rows[4] = {`HM_STOPPER1, 1'b0, 1'b0, `ERR_NONE, 1'b1, 32'h140};
    rows[5] = {`HM_STOPPER2, 1'b0, 1'b0, `ERR_NONE, 1'b1, 32'h140};
    repeat (8) tick;
    `CHK({busy, err, done, spd, zp}, 13'h0)
    $display("reset test ended");
    for (i = 0; i < 6; i++)
    begin
      run(rows[i][45:43], rows[i][42], rows[i][41], 0);
      `CHK(err, rows[i][40:33])
      `CHK(done, rows[i][32])
      `CHK(latch, rows[i][31:0])
      $display("row %0d ended", i);
    end
    hold = 1;
    run(`HM_DATASET1, 1'b0, 1'b1, 0);
    `CHK(done, 1'b0)
    hold = 0;
    repeat (4) tick;
    `CHK(done, 1'b1)
    $display("in-position test ended");
    run(`HM_CRADLE, 1'b0, 1'b0, 0);
    `CHK(done, 1'b1)
    `CHK(latch, 32'h100)
    `CHK(zp, 1'b1)
    go(`HM_CRADLE, 1'b0);
    `CHK({err, busy}, {`ERR_DONE_SET, 1'b0})
    eclr = 1;
    tick;
    eclr = 0;
    tick;
    `CHK(err, `ERR_NONE)
    go(`HM_STOPPER2, 1'b0);
    `CHK({err, spd}, {`ERR_DONE_SET, `SPD_STOP})
    $display("cradle test ended");
    // jog into the dog first, then start the cradle method from inside it
    run(`HM_CRADLE, 1'b0, 1'b0, 50);
    `CHK({done, latch}, {1'b1, 32'h100})
    prep(1'b0, 50);
    method = `HM_STOPPER1;
    retry = 0;
    start_i = 1;
    tick;
    start_i = 0;
    `CHK({spd, tl_en}, {`SPD_CREEP, 1'b1})
    for (i = 0; i < 3000 && busy !== 1'b0; i++) tick;
    `CHK({done, latch}, {1'b1, 32'h140})
    $display("start on dog test ended");
    run(`HM_DATASET2, 1'b0, 1'b0, 0);
    `CHK(err, `ERR_NO_ZERO)
    eclr = 1;
    tick;
    eclr = 0;
    manual_jog_motion = 1;
    repeat (20) tick;
    manual_jog_motion = 0;
    tick;
    go(`HM_DATASET2, 1'b0);
    `CHK({err, done}, {`ERR_NONE, 1'b1})
    $display("clear and jog test ended");
    results;
  end
endmodule // axis_homing_sequencer_bench

// *** sim/axis_homing_sequencer_chk.sv ***
`timescale 1ns/1ps
`include "axis_homing_map.vh"
module axis_homing_sequencer_chk
(
  input wire clock_i,
  input wire resetn_i,
  input wire start_i,
  input wire [`HM_WIDTH-1:0] method_i,
  input wire retry_en_i,
  input wire amp_power_up_i,
  input wire no_z_phase_opt_i,
  input wire zero_pulse_i,
  input wire torque_limiting_i,
  input wire in_position_flag_i,
  input wire [`POS_WIDTH-1:0] real_pos_i,
  input wire [`POS_WIDTH-1:0] home_addr_i,
  input wire [1:0] speed_sel_o,
  input wire torque_limit_en_o,
  input wire pos_load_o,
  input wire [`POS_WIDTH-1:0] pos_load_value_o,
  input wire [`POS_WIDTH-1:0] home_latch_o,
  input wire busy_o,
  input wire home_done_o,
  input wire [`ERR_WIDTH-1:0] minor_error_o,
  input wire zero_pass_flag_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire take = start_i && !busy_o;
  wire stp = method_i == `HM_STOPPER1 || method_i == `HM_STOPPER2;
  property p_inpos; pos_load_o |-> $past(in_position_flag_i); endproperty
  a_inpos: assert property (p_inpos) else $error("load without in-position");
  property p_lval; pos_load_o |-> pos_load_value_o == home_addr_i; endproperty
  a_lval: assert property (p_lval) else $error("bad load value");
  property p_done; $rose(home_done_o) |-> pos_load_o; endproperty
  a_done: assert property (p_done) else $error("done without load");
  property p_crej;
    take && home_done_o && !retry_en_i && method_i == `HM_CRADLE
      |=> minor_error_o == `ERR_DONE_SET && !busy_o;
  endproperty
  a_crej: assert property (p_crej) else $error("cradle not refused");
  property p_srej;
    take && home_done_o && !retry_en_i && stp |=> minor_error_o == `ERR_DONE_SET && !busy_o;
  endproperty
  a_srej: assert property (p_srej) else $error("stopper not refused");
  property p_retry;
    take && !home_done_o && retry_en_i && method_i == `HM_STOPPER1
      |=> minor_error_o == `ERR_RETRY_BAD && !busy_o;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not refused");
  property p_nozero;
    take && method_i <= `HM_DATASET2 && !zero_pass_flag_o && !$past(amp_power_up_i)
      && !$past(zero_pulse_i) |=> minor_error_o == `ERR_NO_ZERO && !busy_o;
  endproperty
  a_nozero: assert property (p_nozero) else $error("no-zero not refused");
  property p_opt; amp_power_up_i && no_z_phase_opt_i |=> ##1 zero_pass_flag_o; endproperty
  a_opt: assert property (p_opt) else $error("option did not set flag");
  property p_zp; zero_pulse_i |=> ##1 zero_pass_flag_o; endproperty
  a_zp: assert property (p_zp) else $error("zero pulse not flagged");
  property p_still; !busy_o |-> speed_sel_o == `SPD_STOP; endproperty
  a_still: assert property (p_still) else $error("motion while idle");
  property p_tlat;
    busy_o && torque_limit_en_o && $rose(torque_limiting_i) |-> ##[1:3] home_latch_o == real_pos_i;
  endproperty
  a_tlat: assert property (p_tlat) else $error("stopper latch wrong");
  property p_s2;
    busy_o && method_i == `HM_STOPPER2 && speed_sel_o != `SPD_STOP
      |-> torque_limit_en_o && speed_sel_o == `SPD_CREEP;
  endproperty
  a_s2: assert property (p_s2) else $error("stopper 2 not creeping limited");
  c_cradle: cover property (busy_o && method_i == `HM_CRADLE ##1 home_done_o);
  c_refuse: cover property (minor_error_o == `ERR_DONE_SET);
  c_load: cover property (pos_load_o);
endmodule // axis_homing_sequencer_chk
bind axis_homing_sequencer axis_homing_sequencer_chk u_axis_homing_sequencer_chk (.clock_i,
  .resetn_i, .start_i, .method_i, .retry_en_i, .amp_power_up_i, .no_z_phase_opt_i,
  .zero_pulse_i, .torque_limiting_i, .in_position_flag_i, .real_pos_i, .home_addr_i,
  .speed_sel_o, .torque_limit_en_o, .pos_load_o, .pos_load_value_o, .home_latch_o,
  .busy_o, .home_done_o, .minor_error_o, .zero_pass_flag_o);

// *** sim/servo_amp_model.sv ***
`timescale 1ns/1ps
module servo_amp_model
#(
  parameter START = 32'h10,
  parameter DOG_LO = 32'hc8,
  parameter DOG_HI = 32'h12c,
  parameter STOP = 32'h140
)
(
  input wire clock_i,
  input wire resetn_i,
  input wire [1:0] speed_sel_i,
  input wire move_dir_i,
  input wire torque_limit_en_i,
  input wire hold_i,
  input wire jog_i,
  output reg zero_pulse_o,
  output wire dog_o,
  output wire torque_limiting_o,
  output wire in_position_o,
  output wire motion_stopped_o,
  output reg [31:0] real_pos_o,
  output wire [31:0] command_pos_o
);
  // manual jog turns the motor forward at homing speed, outside any homing run
  wire [31:0] step = jog_i ? 32'h4 : speed_sel_i == 2'h1 ? 32'h4 : speed_sel_i == 2'h2 ? 32'h1 : 32'h0;
  wire [31:0] raw = (move_dir_i || jog_i) ? real_pos_o + step : real_pos_o - step;
  // the stopper face blocks any travel past it
  wire [31:0] nxt = raw > STOP ? STOP : raw;
  always @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      real_pos_o <= START;
      zero_pulse_o <= 1'b0;
    end
    else
    begin
      real_pos_o <= nxt;
      zero_pulse_o <= nxt[31:6] != real_pos_o[31:6];
    end
  assign dog_o = real_pos_o >= DOG_LO && real_pos_o < DOG_HI;
  assign torque_limiting_o = torque_limit_en_i && real_pos_o == STOP;
  // stops dead, so decel overshoot is never exercised
  assign motion_stopped_o = speed_sel_i == 2'h0;
  assign in_position_o = motion_stopped_o && !hold_i;
  assign command_pos_o = real_pos_o + 32'h5;
endmodule // servo_amp_model
